// File: rtl/touch_count_engine.sv
// counts sense oscillator edges over a measurement window
// assumes sense_i is synchronous to clk_i and the window is never zero
`default_nettype none

module touch_count_engine
    import touch_pkg::*;
#(
    parameter int CNT_W  = COUNT_W,
    parameter int TIME_W = ENG_W
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    // control
    input  wire logic              start_i,
    input  wire logic [TIME_W-1:0] window_i,
    input  wire logic              sense_i,
    // result
    output logic                   busy_o,
    output logic                   done_o,
    output logic [CNT_W-1:0]       count_o
);
    logic [TIME_W-1:0] remain;
    logic [TIME_W-1:0] next_remain;
    logic              prev;
    logic              next_busy;
    logic              next_done;
    logic [CNT_W-1:0]  next_count;

    always_comb begin
        next_remain = remain;
        next_busy   = busy_o;
        next_done   = 1'b0;
        next_count  = count_o;
        if (start_i) begin
            next_busy   = 1'b1;
            next_remain = window_i;
            next_count  = '0;
        end else if (busy_o) begin
            if (sense_i && !prev && count_o != '1) begin
                next_count = count_o + 1'b1;
            end
            next_remain = remain - 1'b1;
            if (remain == TIME_W'(1)) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            remain  <= '0;
            prev    <= 1'b0;
            busy_o  <= 1'b0;
            done_o  <= 1'b0;
            count_o <= '0;
        end else begin
            remain  <= next_remain;
            prev    <= sense_i;
            busy_o  <= next_busy;
            done_o  <= next_done;
            count_o <= next_count;
        end
    end
endmodule

`default_nettype wire

// File: rtl/touch_key_scan_controller.sv
// touch key scan controller: registers, pin assignment, scan sequencer
// assumes a classic Wishbone master and synchronous sense oscillator input
//
// The register addresses and register access over Wishbone were chosen for this implementation.
`default_nettype none

module touch_key_scan_controller
    import touch_pkg::*;
#(
    parameter int UNIT_CYCLES = WINDOW_UNIT_CYCLES
) (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    // wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [11:0]           wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic [31:0]                wb_dat_o,
    output logic                       wb_ack_o,
    // pins
    input  wire logic [2*PIN_COUNT-1:0] port_pin_mode_i,
    input  wire logic                  sense_i,
    output logic [PIN_COUNT-1:0]       touch_channel_en_o,
    output logic [CHAN_W-1:0]          sense_channel_o,
    output logic [TRIM_W-1:0]          sense_trim_o,
    output logic                       sense_active_o,
    output logic [1:0]                 sense_clk_div_o
);
    // ****************************************
    // state
    // ****************************************
    logic               pd, rerun, hop, start, done, scanning;
    logic [WIN_W-1:0]   win;
    logic [1:0]         mode;
    logic [4:0]         first_ch, order;
    logic [23:0]        fsel, mask;
    logic [TRIM_W-1:0]  trim [TRIM_COUNT];
    logic [COUNT_W-1:0] results [SLOT_COUNT];
    logic [5:0]         shadow;
    logic [2:0]         rep;
    logic [3:0]         lfsr;
    logic               launch;
    scan_state_e        state;

    logic               next_pd, next_rerun, next_hop, next_start, next_done;
    logic               next_scanning, next_ack, next_launch, next_active;
    logic [WIN_W-1:0]   next_win;
    logic [1:0]         next_mode, next_div;
    logic [4:0]         next_first, next_order, next_cur;
    logic [23:0]        next_fsel, next_mask;
    logic [TRIM_W-1:0]  next_trim [TRIM_COUNT];
    logic [COUNT_W-1:0] next_results [SLOT_COUNT];
    logic [5:0]         next_shadow;
    logic [2:0]         next_rep;
    logic [3:0]         next_lfsr;
    logic [31:0]        next_dat, rd_word, wd;
    logic [PIN_COUNT-1:0] next_en;
    logic [TRIM_W-1:0]  next_trim_out;
    scan_state_e        next_state;

    logic               access, wr, wr_start, wr_stop, trim_hit, finishing;
    logic [4:0]         trim_idx, slot;
    logic [5:0]         nxt;
    logic [3:0]         reps;
    logic [ENG_W-1:0]   win_cycles;
    logic               eng_done;
    logic [COUNT_W-1:0] eng_count;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        for (int b = 0; b < 4; b++) begin
            merge[8*b+:8] = sel[b] ? nw[8*b+:8] : old[8*b+:8];
        end
    endfunction

    function automatic logic [5:0] next_set(input logic [23:0] m, input logic [4:0] cur);
        next_set = 6'h00;
        for (int i = 23; i >= 0; i--) begin
            if (m[i] && 5'(i) > cur) begin
                next_set = {1'b1, 5'(i)};
            end
        end
    endfunction

    function automatic logic [4:0] slot_of(input logic scan, input logic [1:0] md,
                                           input logic [4:0] ch, input logic [4:0] ord,
                                           input logic [2:0] rp);
        if (!scan || md == 2'h0) begin
            slot_of = ch;
        end else begin
            slot_of = 5'((ord << md) | 5'(rp));
        end
    endfunction

    // ****************************************
    // measurement engine
    // ****************************************
    assign win_cycles = ENG_W'((ENG_W'(win) + 1'b1) * UNIT_CYCLES);

    touch_count_engine #(
        .CNT_W  (COUNT_W),
        .TIME_W (ENG_W)
    ) engine (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .start_i  (launch),
        .window_i (win_cycles),
        .sense_i  (sense_i),
        .busy_o   (),
        .done_o   (eng_done),
        .count_o  (eng_count)
    );

    // ****************************************
    // register bus
    // ****************************************
    assign trim_idx = wb_adr_i[6:2];
    assign trim_hit = wb_adr_i[11:8] == TRIM_REGION && !wb_adr_i[7] && trim_idx < 5'd24;

    always_comb begin
        rd_word = 32'h0000_0000;
        case (wb_adr_i)
            CTRL_OFS:      rd_word = {22'h0, mode, win, hop, rerun, done, start, pd};
            FIRST_OFS:     rd_word = {27'h0, first_ch};
            FSEL_LOW_OFS:  rd_word = {24'h0, fsel[7:0]};
            FSEL_MID_OFS:  rd_word = {24'h0, fsel[15:8]};
            FSEL_HIGH_OFS: rd_word = {24'h0, fsel[23:16]};
            MASK_OFS:      rd_word = {8'h0, mask};
            default: begin
                if (trim_hit) begin
                    rd_word = {25'h0, trim[trim_idx]};
                end else if (wb_adr_i[11:8] == RESULT_REGION) begin
                    rd_word = wb_adr_i[2] ? {26'h0, shadow}
                                          : {24'h0, results[wb_adr_i[7:3]][7:0]};
                end
            end
        endcase
    end

    always_comb begin
        access        = wb_cyc_i && wb_stb_i && wb_ack_o;
        wr            = access && wb_we_i;
        wd            = merge(rd_word, wb_dat_i, wb_sel_i);
        next_ack      = wb_cyc_i && wb_stb_i && !wb_ack_o;
        next_dat      = next_ack ? rd_word : 32'h0000_0000;
        next_pd       = pd;
        next_rerun    = rerun;
        next_hop      = hop;
        next_win      = win;
        next_mode     = mode;
        next_first    = first_ch;
        next_fsel     = fsel;
        next_mask     = mask;
        next_trim     = trim;
        next_shadow   = shadow;
        wr_start      = 1'b0;
        wr_stop       = 1'b0;
        if (next_ack && !wb_we_i && wb_adr_i[11:8] == RESULT_REGION && !wb_adr_i[2]) begin
            next_shadow = results[wb_adr_i[7:3]][13:8];
        end
        if (wr) begin
            case (wb_adr_i)
                CTRL_OFS: begin
                    next_pd    = wd[PD_BIT];
                    next_rerun = wd[RERUN_BIT];
                    next_hop   = wd[HOP_BIT];
                    next_win   = wd[WIN_LSB+:WIN_W];
                    next_mode  = wd[MODE_LSB+:2];
                    wr_start   = wb_sel_i[0] && wb_dat_i[START_BIT];
                    wr_stop    = wb_sel_i[0] && !wb_dat_i[START_BIT];
                end
                FIRST_OFS:     next_first = wd[4:0];
                FSEL_LOW_OFS:  next_fsel[7:0] = wd[7:0];
                FSEL_MID_OFS:  next_fsel[15:8] = wd[7:0];
                FSEL_HIGH_OFS: next_fsel[23:16] = wd[7:0] & MASK_VALID[23:16];
                MASK_OFS:      next_mask = wd[23:0] & MASK_VALID;
                default: begin
                    if (trim_hit) begin
                        next_trim[trim_idx] = wd[TRIM_W-1:0];
                    end
                end
            endcase
        end
        for (int i = 0; i < PIN_COUNT; i++) begin
            next_en[i] = fsel[i] || port_pin_mode_i[2*i+:2] == PIN_MODE_TOUCH;
        end
        next_trim_out = trim[sense_channel_o];
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wb_ack_o           <= 1'b0;
            wb_dat_o           <= 32'h0000_0000;
            pd                 <= PD_RESET;
            rerun              <= 1'b0;
            hop                <= 1'b0;
            win                <= WIN_RESET;
            mode               <= 2'h0;
            first_ch           <= FIRST_RESET;
            fsel               <= 24'h00_0000;
            mask               <= 24'h00_0000;
            trim               <= '{default: '0};
            shadow             <= 6'h00;
            touch_channel_en_o <= '0;
            sense_trim_o       <= '0;
        end else begin
            wb_ack_o           <= next_ack;
            wb_dat_o           <= next_dat;
            pd                 <= next_pd;
            rerun              <= next_rerun;
            hop                <= next_hop;
            win                <= next_win;
            mode               <= next_mode;
            first_ch           <= next_first;
            fsel               <= next_fsel;
            mask               <= next_mask;
            trim               <= next_trim;
            shadow             <= next_shadow;
            touch_channel_en_o <= next_en;
            sense_trim_o       <= next_trim_out;
        end
    end

    // ****************************************
    // scan sequencer
    // ****************************************
    assign reps      = 4'h1 << mode;
    assign slot      = slot_of(scanning, mode, sense_channel_o, order, rep);
    assign nxt       = next_set(mask, sense_channel_o);
    assign finishing = state == ST_STORE
                       && !(scanning && 4'(rep) + 1'b1 < reps)
                       && !(scanning && nxt[5] && 6'(order) + 1'b1 < max_channels(mode));

    always_comb begin
        next_state    = state;
        next_start    = start;
        next_done     = done;
        next_scanning = scanning;
        next_cur      = sense_channel_o;
        next_order    = order;
        next_rep      = rep;
        next_lfsr     = lfsr;
        next_results  = results;
        next_launch   = 1'b0;
        case (state)
            ST_IDLE: begin
                if (start && !pd) begin
                    next_cur      = first_ch;
                    next_order    = 5'h00;
                    next_rep      = 3'h0;
                    next_scanning = |mask;
                    next_done     = 1'b0;
                    next_launch   = 1'b1;
                    next_state    = ST_CONV;
                end
            end
            ST_CONV: begin
                if (pd) begin
                    next_start = 1'b0;
                    next_state = ST_IDLE;
                end else if (eng_done) begin
                    next_state = ST_STORE;
                end
            end
            ST_STORE: begin
                next_results[slot] = eng_count;
                if (scanning && 4'(rep) + 1'b1 < reps) begin
                    next_rep    = rep + 1'b1;
                    next_launch = 1'b1;
                    next_state  = ST_CONV;
                end else if (!finishing) begin
                    next_cur    = nxt[4:0];
                    next_order  = order + 1'b1;
                    next_rep    = 3'h0;
                    next_launch = 1'b1;
                    next_state  = ST_CONV;
                end else begin
                    next_done  = 1'b1;
                    next_start = rerun;
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        if (next_launch && hop) begin
            next_lfsr = {lfsr[2:0], lfsr[3] ^ lfsr[2]};
        end
        if (wr_stop) begin
            next_start = 1'b0;
        end
        if (wr_start) begin
            next_start = 1'b1;
        end
        next_div    = hop ? next_lfsr[1:0] : 2'h0;
        next_active = next_state == ST_CONV;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state           <= ST_IDLE;
            start           <= 1'b0;
            done            <= 1'b0;
            scanning        <= 1'b0;
            sense_channel_o <= '0;
            order           <= 5'h00;
            rep             <= 3'h0;
            lfsr            <= LFSR_SEED;
            results         <= '{default: '0};
            launch          <= 1'b0;
            sense_active_o  <= 1'b0;
            sense_clk_div_o <= 2'h0;
        end else begin
            state           <= next_state;
            start           <= next_start;
            done            <= next_done;
            scanning        <= next_scanning;
            sense_channel_o <= next_cur;
            order           <= next_order;
            rep             <= next_rep;
            lfsr            <= next_lfsr;
            results         <= next_results;
            launch          <= next_launch;
            sense_active_o  <= next_active;
            sense_clk_div_o <= next_div;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    logic [ENG_W:0] conv_len;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            conv_len <= '0;
        end else begin
            conv_len <= (state == ST_CONV) ? conv_len + 1'b1 : '0;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    force_sel_a: assert property (fsel[0] |=> touch_channel_en_o[0])
        else $error("forced pin not enabled");
    start_clear_a: assert property (finishing && !rerun && !wr_start |=> !start)
        else $error("start not cleared at end");
    done_low_a: assert property (state == ST_CONV |-> !done)
        else $error("done high during conversion");
    rerun_keep_a: assert property (finishing && rerun && !wr_stop |=> start)
        else $error("rerun did not keep running");
    window_len_a: assert property (eng_done && state == ST_CONV |->
                                   conv_len == ENG_W'(win_cycles) + 1'b1)
        else $error("window length wrong");
    first_chan_a: assert property ($rose(sense_active_o) && !scanning |->
                                   sense_channel_o == $past(first_ch, 2))
        else $error("first channel not used");
    hop_off_a: assert property (!hop |=> sense_clk_div_o == 2'h0)
        else $error("clock varied without hop");
    trim_out_a: assert property (1'b1 |=> sense_trim_o == $past(trim[sense_channel_o]))
        else $error("trim output wrong");
    mask_only_a: assert property (state == ST_CONV && scanning && order != 5'h00 |->
                                  mask[sense_channel_o])
        else $error("unmasked channel scanned");
    chan_limit_a: assert property (state == ST_STORE && scanning |->
                                   6'(order) < max_channels(mode))
        else $error("channel limit exceeded");
    mode0_slot_a: assert property (state == ST_STORE && !scanning |=>
                                   results[$past(sense_channel_o)] == $past(eng_count))
        else $error("result slot wrong");
    mode1_slot_a: assert property (state == ST_STORE && scanning && mode == 2'h1 |=>
                                   results[$past({order[3:0], rep[0]})] == $past(eng_count))
        else $error("mode one slot wrong");
    high_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[11:8] == RESULT_REGION |->
                                  wb_dat_o[31:8] == 24'h0)
        else $error("result read too wide");
    done_late_a: assert property ($rose(done) && scanning |->
                                  $past(4'(rep)) + 1'b1 >= reps)
        else $error("done before repeats");

    scan_done_c: cover property (state == ST_STORE && finishing && scanning && mode == 2'h1);
    rerun_c: cover property (finishing && rerun ##2 state == ST_CONV);
    cap_chan_c: cover property (state == ST_CONV && sense_channel_o == CAP_CHANNEL);
endmodule

`default_nettype wire

// File: rtl/touch_pkg.sv
// constants, register map and types of the touch key scan controller
// assumes a 250 MHz system clock and a 32-bit classic Wishbone register bus
`default_nettype none

package touch_pkg;
    // ****************************************
    // sizes
    // ****************************************
    localparam int          PIN_COUNT      = 20;
    localparam int          CHAN_W         = 5;
    localparam int          COUNT_W        = 14;
    localparam int          TRIM_W         = 7;
    localparam int          TRIM_COUNT     = 24;
    localparam int          SLOT_COUNT     = 32;
    localparam int          WIN_W          = 3;
    localparam int          ENG_W          = 10;
    localparam logic [4:0]  CAP_CHANNEL    = 5'h17;
    localparam logic [1:0]  PIN_MODE_TOUCH = 2'h3;
    localparam logic [23:0] MASK_VALID     = 24'h8F_FFFF;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [11:0] CTRL_OFS       = 12'h000;
    localparam logic [11:0] FIRST_OFS      = 12'h004;
    localparam logic [11:0] FSEL_LOW_OFS   = 12'h008;
    localparam logic [11:0] FSEL_MID_OFS   = 12'h00C;
    localparam logic [11:0] FSEL_HIGH_OFS  = 12'h010;
    localparam logic [11:0] MASK_OFS       = 12'h014;
    localparam logic [3:0]  TRIM_REGION    = 4'h1;
    localparam logic [3:0]  RESULT_REGION  = 4'h2;

    // ****************************************
    // control fields and reset values
    // ****************************************
    localparam int          PD_BIT         = 0;
    localparam int          START_BIT      = 1;
    localparam int          DONE_BIT       = 2;
    localparam int          RERUN_BIT      = 3;
    localparam int          HOP_BIT        = 4;
    localparam int          WIN_LSB        = 5;
    localparam int          MODE_LSB       = 8;
    localparam logic        PD_RESET       = 1'b1;
    localparam logic [2:0]  WIN_RESET      = 3'h3;
    localparam logic [4:0]  FIRST_RESET    = 5'h00;
    localparam logic [3:0]  LFSR_SEED      = 4'h1;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_PS      = 4000;
    localparam int WINDOW_UNIT_NS     = 256;
    localparam int WINDOW_UNIT_CYCLES =
        (WINDOW_UNIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_CONV  = 3'b010,
        ST_STORE = 3'b100
    } scan_state_e;

    function automatic logic [5:0] max_channels(input logic [1:0] mode);
        max_channels = (mode == 2'h0) ? 6'd21 : (6'd32 >> mode);
    endfunction
endpackage

`default_nettype wire

// File: test/sense_osc_model.sv
// sense oscillator model for the touch electrodes
// assumes it shares the controller clock and sees its channel and window
`default_nettype none
module sense_osc_model (
    input  wire logic       clk_i,
    input  wire logic       active_i,
    input  wire logic [4:0] channel_i,
    output logic            sense_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt;
    // channel-dependent rate, held low outside a window
    always @(posedge clk_i) begin
        cnt <= (active_i && cnt != 3'h0) ? cnt - 3'h1 : {1'b0, channel_i[1:0]} + 3'h1;
        sense_o <= active_i ? sense_o ^ (cnt == 3'h0) : 1'b0;
    end
endmodule
`default_nettype wire

// File: test/tb_touch_key_scan_controller.sv
// testbench of the touch key scan controller
// assumes the sense oscillator model on the far side
`default_nettype none
module tb_touch_key_scan_controller
    import touch_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  sel = 4'hF;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, rd;
    logic [39:0] mode = 40'h0;
    logic [19:0] ten;
    logic [13:0] cnt;
    logic [6:0]  trim;
    logic [4:0]  chan;
    logic [1:0]  div;
    logic        ack, act, sense;
    int          bad_count = 0;
    int          checks = 0;
    always #2 clk_i = ~clk_i;
    touch_key_scan_controller #(.UNIT_CYCLES(16)) touch_key_scan_controller_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .port_pin_mode_i(mode), .sense_i(sense), .touch_channel_en_o(ten),
        .sense_channel_o(chan), .sense_trim_o(trim), .sense_active_o(act),
        .sense_clk_div_o(div));
    sense_osc_model sense_osc_model_inst (.clk_i(clk_i), .active_i(act),
        .channel_i(chan), .sense_o(sense));
    task automatic report_and_stop();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            bad_count++;
            report_and_stop();
        end
        rd = rdat;
        cyc <= 1'b0;
    endtask
    task automatic near(input string nm, input int lo, input int hi);
        chk(nm, 32'h1, {31'h0, cnt >= lo && cnt <= hi});
    endtask
    task automatic res(input logic [4:0] slot);
        wb(1'b0, 12'h200 | {4'h0, slot, 3'h0}, 32'h0);
        cnt[7:0] = rd[7:0];
        wb(1'b0, 12'h204 | {4'h0, slot, 3'h0}, 32'h0);
        cnt[13:8] = rd[5:0];
    endtask
    task automatic conv(input logic [4:0] ch, input logic [31:0] ctrl, input logic [6:0] et);
        int n;
        wb(1'b1, FIRST_OFS, 32'(ch));
        wb(1'b1, CTRL_OFS, ctrl);
        wb(1'b0, CTRL_OFS, 32'h0);
        chk("busy flags", 32'h2, rd & 32'h6);
        chk("channel", 32'(ch), 32'(chan));
        chk("trim", 32'(et), 32'(trim));
        chk("no hop", 32'h0, 32'(div));
        n = 0;
        do begin
            wb(1'b0, CTRL_OFS, 32'h0);
            n++;
        end while (rd[DONE_BIT] !== 1'b1 && n < 1000);
        if (rd[DONE_BIT] !== 1'b1) begin
            bad_count++;
            report_and_stop();
        end
        chk("end flags", 32'h4, rd & 32'h6);
        repeat (12500) @(posedge clk_i);
    endtask
    task automatic t_window();
        conv(5'd0, 32'h02, 7'h00);
        res(5'd0);
        near("short window", 3, 5);
        conv(5'd0, 32'hE2, 7'h00);
        res(5'd0);
        near("long window", 31, 33);
    endtask
    task automatic t_cap();
        wb(1'b1, 12'h15C, 32'h5A);
        wb(1'b0, 12'h15C, 32'h0);
        chk("trim reg", 32'h5A, rd);
        conv(5'h17, 32'h62, 7'h5A);
        res(5'd23);
        near("cap result", 5, 7);
    endtask
    task automatic t_scan();
        wb(1'b1, MASK_OFS, 32'h24);
        conv(5'd2, 32'h162, 7'h00);
        for (int s = 0; s < 4; s++) begin
            res(5'(s));
            if (s < 2) near("scan first", 7, 9);
            else near("scan second", 10, 12);
        end
        conv(5'd2, 32'h262, 7'h00);
        res(5'd3);
        near("mode two first", 7, 9);
        res(5'd4);
        near("mode two second", 10, 12);
        conv(5'd2, 32'h362, 7'h00);
        res(5'd7);
        near("mode three first", 7, 9);
        res(5'd8);
        near("mode three second", 10, 12);
    endtask
    task automatic t_rerun();
        int n;
        logic was;
        logic [3:0] seen;
        n = 0;
        was = 1'b0;
        seen = 4'h0;
        wb(1'b1, CTRL_OFS, 32'h17A);
        repeat (600) begin
            @(posedge clk_i);
            if (act === 1'b1 && !was) begin
                n++;
                seen[div] = 1'b1;
            end
            was = (act === 1'b1);
        end
        chk("relaunch", 32'h1, {31'h0, n > 4});
        chk("hop varies", 32'h1, {31'h0, $countones(seen) > 1});
        wb(1'b1, CTRL_OFS, 32'h61);
    endtask
    task automatic t_regs();
        wb(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl reset", 32'h61, rd);
        wb(1'b0, 12'hFF0, 32'h0);
        chk("unmapped", 32'h0, rd);
        mode[3:2] <= 2'b11;
        wb(1'b1, FSEL_LOW_OFS, 32'h01);
        wb(1'b1, FSEL_HIGH_OFS, 32'h08);
        repeat (2) @(posedge clk_i);
        chk("pin enables", 32'h80003, 32'(ten));
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_window();
        t_cap();
        t_scan();
        t_rerun();
        report_and_stop();
    end
endmodule
`default_nettype wire
